// [rtl/mnf_negotiator.sv]
// Purpose: Master negotiation state machine of a configuring node
// Assumes: Message framing, topology walk and tables live outside
// Notes:   All message inputs are one-cycle pulses on clk
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps

module mnf_negotiator
    import mnf_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = (`MNF_CLK_HZ / 1000000) * `MNF_TICK_US,
    parameter int unsigned TMO_TICKS   = `MNF_TMO_MS * 1000 / `MNF_TICK_US
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    srst,
    // Register port
    input  wire logic [`MNF_ADDR_W-1:0]  reg_addr,
    input  wire logic [31:0]             reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [31:0]             reg_rdata,
    // Received query-node message
    input  wire logic                    rx_query,
    input  wire logic                    rx_query_ma,
    input  wire logic                    rx_query_master,
    // Received query-node reply
    input  wire logic                    rx_reply,
    input  wire logic                    rx_reply_cm,
    // Sender of the received message
    input  wire logic [`MNF_NODE_W-1:0]  rx_node,
    input  wire logic [`MNF_PRIO_W-1:0]  rx_prio,
    input  wire logic [`MNF_UID_W-1:0]   rx_uid,
    // Alert traffic
    input  wire logic                    alert_in,
    input  wire logic                    alert_done,
    input  wire logic                    port_op_alert,
    input  wire logic                    port_op_new_subweb,
    input  wire logic                    async_reply_in,
    input  wire logic                    mst_alert_in,
    // Topology and configuration
    input  wire logic                    attach_nocfg,
    input  wire logic                    cfg_done,
    input  wire logic [`MNF_PRIO_W-1:0]  best_prio,
    input  wire logic [`MNF_UID_W-1:0]   best_uid,
    // Outgoing messages
    output logic                         tx_valid,
    output mnf_tx_e                      tx_kind,
    output logic [`MNF_NODE_W-1:0]       tx_node,
    output logic                         tx_bcast,
    output logic                         tx_cm,
    output logic                         tx_ma,
    // Status and control to neighbours
    output logic                         alert_accept,
    output logic                         cfg_start,
    output logic                         cfg_abort,
    output logic                         walk_start,
    output logic                         notify_attach,
    output logic                         tbl_wr,
    output logic [`MNF_NODE_W-1:0]       tbl_node,
    output logic [`MNF_PRIO_W-1:0]       tbl_prio,
    output mnf_role_e                    role
);

    // ------------
    // Helpers
    // ------------
    // True when the other node beats us
    function automatic logic other_wins(input logic [`MNF_PRIO_W-1:0] mp, input logic [`MNF_UID_W-1:0] mu,
                                        input logic [`MNF_PRIO_W-1:0] op, input logic [`MNF_UID_W-1:0] ou);
        other_wins = (op > mp) || ((op == mp) && (ou > mu));
    endfunction

    function automatic logic [`MNF_NODE_W-1:0] first_set(input logic [`MNF_NODES-1:0] v);
        first_set = '0;
        for (int i = `MNF_NODES - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_set = i[`MNF_NODE_W-1:0];
            end
        end
    endfunction

    mnf_state_s s_q;
    mnf_state_s s_d;

    logic is_mastering;
    logic lose;
    logic wr_prio;
    logic wr_ctrl;
    logic elect_req;
    logic new_loses;

    assign is_mastering = (s_q.role == ROLE_MASTER) || (s_q.role == ROLE_PENDING) || (s_q.role == ROLE_ASSUME);
    assign lose         = other_wins(s_q.prio, s_q.uid, rx_prio, rx_uid);
    assign new_loses    = other_wins(reg_wdata[`MNF_PRIO_W-1:0], s_q.uid, best_prio, best_uid);
    assign wr_prio      = reg_wr && (reg_addr == `MNF_OFS_PRIO);
    assign wr_ctrl      = reg_wr && (reg_addr == `MNF_OFS_CTRL);
    assign elect_req    = wr_ctrl && reg_wdata[`MNF_CTRL_ELECT];

    // ------------
    // Next state
    // ------------
    always_comb begin
        s_d = s_q;
        s_d.tx_kind = TX_NONE;
        {s_d.tx_valid, s_d.tx_cm, s_d.tx_ma, s_d.tx_bcast, s_d.cfg_start} = 5'h00;
        {s_d.cfg_abort, s_d.walk_start, s_d.notify_attach, s_d.tbl_wr} = 4'h0;

        if (wr_ctrl) begin
            s_d.en = reg_wdata[`MNF_CTRL_EN];
            if (reg_wdata[`MNF_CTRL_MASTER] && s_q.role == ROLE_NODE) begin
                s_d.role = ROLE_MASTER;
            end
        end
        if (reg_wr && reg_addr == `MNF_OFS_UID) begin
            s_d.uid = reg_wdata[`MNF_UID_W-1:0];
        end
        if (wr_prio) begin
            s_d.prio = reg_wdata[`MNF_PRIO_W-1:0];
        end

        // Read data for the next cycle
        s_d.rdata = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                `MNF_OFS_CTRL:   s_d.rdata = {31'h0, s_q.en};
                `MNF_OFS_PRIO:   s_d.rdata = {24'h0, s_q.prio};
                `MNF_OFS_UID:    s_d.rdata = {16'h0, s_q.uid};
                `MNF_OFS_STATUS: s_d.rdata = {8'h0, s_q.alerts, 5'h0, s_q.phase, 2'h0, s_q.role};
                `MNF_OFS_LOGS:   s_d.rdata = {16'h0, s_q.await_q, s_q.log_q};
                default:         s_d.rdata = '0;
            endcase
        end

        // Outstanding alert count; none accepted while resigning
        if (alert_in && !s_q.lowering && s_q.role != ROLE_RESIGN) begin
            s_d.alerts = s_q.alerts + 1'b1;
        end
        if (alert_done && s_q.alerts != '0) begin
            s_d.alerts = s_d.alerts - 1'b1;
        end

        // Watchdog prescaler
        if (s_q.phase != PH_IDLE) begin
            if (s_q.pre == TICK_CYCLES[`MNF_TICK_W-1:0] - 1'b1) begin
                s_d.pre   = '0;
                s_d.ticks = s_q.ticks + 1'b1;
            end else begin
                s_d.pre = s_q.pre + 1'b1;
            end
        end

        if (!s_q.en) begin
            // Disabled: hold, transmit nothing
        end else if (rx_query) begin
            s_d.tx_valid = 1'b1;
            s_d.tx_kind  = TX_REPLY;
            s_d.tx_node  = rx_node;
            if (rx_query_ma && s_q.await_q[rx_node]) begin
                // Formal resignation arrives
                s_d.await_q[rx_node] = 1'b0;
            end else if (rx_query_ma) begin
                s_d.tx_cm = 1'b0;
            end else if (lose && (is_mastering || s_q.role == ROLE_RESIGN)) begin
                s_d.tx_cm           = 1'b1;
                s_d.log_q[rx_node]  = 1'b1;
                s_d.cfg_abort       = (s_q.role == ROLE_ASSUME);
                s_d.role            = ROLE_RESIGN;
            end else if (!lose && rx_query_master && is_mastering) begin
                s_d.tx_cm            = 1'b1;
                s_d.await_q[rx_node] = 1'b1;
                s_d.role             = (s_q.role == ROLE_MASTER) ? ROLE_PENDING : s_q.role;
                if (s_q.phase == PH_IDLE) begin
                    s_d.phase = PH_WAIT1;
                    s_d.pre   = '0;
                    s_d.ticks = '0;
                end
            end else begin
                s_d.tx_cm = 1'b0;
            end
        end else if (rx_reply && s_q.await_q[rx_node]) begin
            if (s_q.phase == PH_WAIT2 && !rx_reply_cm) begin
                s_d.await_q[rx_node] = 1'b0;
            end else if (rx_reply_cm) begin
                s_d.phase = PH_WAIT1;
                s_d.pre   = '0;
                s_d.ticks = '0;
            end
        end else if (rx_reply && rx_reply_cm && !lose && s_q.role == ROLE_MASTER) begin
            // Another Master confirmed our request
            s_d.await_q[rx_node] = 1'b1;
            s_d.role             = ROLE_PENDING;
            s_d.phase            = PH_WAIT1;
            s_d.pre              = '0;
            s_d.ticks            = '0;
        end else if (mst_alert_in) begin
            s_d.tbl_wr   = 1'b1;
            s_d.tbl_node = rx_node;
            s_d.tbl_prio = rx_prio;
            s_d.tx_valid = 1'b1;
            s_d.tx_kind  = TX_RESPONSE;
            s_d.tx_node  = rx_node;
        end else if (attach_nocfg && is_mastering) begin
            s_d.tx_valid    = 1'b1;
            s_d.tx_kind     = TX_WEB_RESET;
            s_d.tx_node     = rx_node;
            s_d.attach_hold = 1'b1;
            s_d.attach_node = rx_node;
        end else if (s_q.attach_hold) begin
            s_d.notify_attach = 1'b1;
            s_d.attach_hold   = 1'b0;
        end else if (port_op_alert && s_q.role == ROLE_ASSUME) begin
            if (port_op_new_subweb) begin
                s_d.walk_start = 1'b1;
            end else begin
                s_d.tx_valid = 1'b1;
                s_d.tx_kind  = TX_ASYNC_RPL;
            end
        end else if (wr_prio && s_q.role == ROLE_MASTER && new_loses) begin
            s_d.lowering = 1'b1;
            s_d.tx_valid = 1'b1;
            s_d.tx_kind  = TX_MST_ALERT;
            s_d.tx_bcast = 1'b1;
        end else if (wr_prio && s_q.role == ROLE_NODE) begin
            s_d.tx_valid  = 1'b1;
            s_d.tx_kind   = TX_ASYNC_ALR;
            s_d.wait_arpl = !new_loses;
        end else if (async_reply_in && s_q.wait_arpl) begin
            s_d.wait_arpl = 1'b0;
            s_d.tx_valid  = 1'b1;
            s_d.tx_kind   = TX_CFG_PORT;
            s_d.tx_bcast  = 1'b1;
            s_d.role      = ROLE_MASTER;
        end else if (elect_req && (s_q.role == ROLE_NODE || s_q.role == ROLE_DONE) &&
                     !other_wins(s_q.prio, s_q.uid, best_prio, best_uid)) begin
            s_d.tx_valid = 1'b1;
            s_d.tx_kind  = TX_CFG_PORT;
            s_d.tx_bcast = 1'b1;
            s_d.role     = ROLE_MASTER;
        end else if (s_q.role == ROLE_RESIGN && s_q.alerts == '0) begin
            if (s_q.log_q != '0) begin
                s_d.tx_valid = 1'b1;
                s_d.tx_kind = TX_QUERY;
                s_d.tx_ma = 1'b1;
                s_d.tx_node = first_set(s_q.log_q);
                s_d.log_q[first_set(s_q.log_q)] = 1'b0;
            end else begin
                s_d.role    = ROLE_DONE;
                s_d.await_q = '0;
                s_d.phase   = PH_IDLE;
            end
        end else if (s_q.lowering && s_q.alerts == '0) begin
            s_d.lowering = 1'b0;
            s_d.role     = ROLE_DONE;
        end else if (s_q.phase != PH_IDLE && s_q.ticks == TMO_TICKS[`MNF_TICK_W-1:0]) begin
            s_d.pre      = '0;
            s_d.ticks    = '0;
            s_d.tx_valid = 1'b1;
            s_d.tx_node  = first_set(s_q.await_q);
            if (s_q.phase == PH_WAIT1) begin
                s_d.tx_kind = TX_QUERY;
                s_d.tx_cm   = 1'b1;
                s_d.phase   = PH_WAIT2;
            end else begin
                s_d.tx_kind = TX_TOTAL_RST;
                s_d.await_q[first_set(s_q.await_q)] = 1'b0;
                s_d.phase = PH_WAIT1;
            end
        end else if (s_q.role == ROLE_PENDING && s_q.await_q == '0) begin
            s_d.role      = ROLE_ASSUME;
            s_d.phase     = PH_IDLE;
            s_d.cfg_start = 1'b1;
        end else if (s_q.role == ROLE_ASSUME && cfg_done) begin
            s_d.role = ROLE_MASTER;
        end

        // Watchdog idles once nothing is awaited
        if (s_d.await_q == '0) begin
            s_d.phase = PH_IDLE;
        end
    end

    // ------------
    // State register
    // ------------
    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= '0;
            s_q.role <= ROLE_NODE;
            s_q.phase <= PH_IDLE;
            s_q.prio <= `MNF_RST_PRIO;
            s_q.uid <= `MNF_RST_UID;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------
    // Outputs
    // ------------
    assign reg_rdata = s_q.rdata;
    assign tx_valid = s_q.tx_valid;
    assign tx_kind = s_q.tx_kind;
    assign tx_node = s_q.tx_node;
    assign tx_bcast = s_q.tx_bcast;
    assign tx_cm = s_q.tx_cm;
    assign tx_ma = s_q.tx_ma;
    assign alert_accept = s_q.en && !s_q.lowering && s_q.role != ROLE_RESIGN;
    assign cfg_start = s_q.cfg_start;
    assign cfg_abort = s_q.cfg_abort;
    assign walk_start = s_q.walk_start;
    assign notify_attach = s_q.notify_attach;
    assign tbl_wr = s_q.tbl_wr;
    assign tbl_node = s_q.tbl_node;
    assign tbl_prio = s_q.tbl_prio;
    assign role = s_q.role;

endmodule

// [common/mnf_cfg.svh]
// Purpose: Constants of the master negotiation controller
// Assumes: 10 MHz clock
// Notes:   Offsets are byte addresses on the plain register port
`ifndef MNF_CFG_SVH
`define MNF_CFG_SVH

// ------------
// Widths
// ------------
`define MNF_PRIO_W      8
`define MNF_UID_W       16
`define MNF_NODE_W      3
`define MNF_NODES       8
`define MNF_ADDR_W      8
`define MNF_ALERT_W     8
`define MNF_TICK_W      16

// ------------
// Register map
// ------------
`define MNF_OFS_CTRL    8'h00
`define MNF_OFS_PRIO    8'h04
`define MNF_OFS_UID     8'h08
`define MNF_OFS_STATUS  8'h0c
`define MNF_OFS_LOGS    8'h10
`define MNF_CTRL_EN     0
`define MNF_CTRL_MASTER 1
`define MNF_CTRL_ELECT  2
`define MNF_RST_PRIO    8'h00
`define MNF_RST_UID     16'h0001

// ------------
// Timing
// ------------
`define MNF_CLK_HZ      10000000
`define MNF_TICK_US     1000
`define MNF_TMO_MS      5000

`endif

// [common/mnf_pkg.sv]
// Purpose: Types of the master negotiation controller
// Assumes: mnf_cfg.svh widths
// Notes:   One-hot state codes
`include "mnf_cfg.svh"

package mnf_pkg;

    typedef enum logic [5:0] {
        ROLE_NODE    = 6'h01,
        ROLE_MASTER  = 6'h02,
        ROLE_PENDING = 6'h04,
        ROLE_ASSUME  = 6'h08,
        ROLE_RESIGN  = 6'h10,
        ROLE_DONE    = 6'h20
    } mnf_role_e;

    typedef enum logic [2:0] {
        PH_IDLE  = 3'h1,
        PH_WAIT1 = 3'h2,
        PH_WAIT2 = 3'h4
    } mnf_phase_e;

    typedef enum logic [3:0] {
        TX_NONE      = 4'h0,
        TX_REPLY     = 4'h1,
        TX_QUERY     = 4'h2,
        TX_TOTAL_RST = 4'h3,
        TX_CFG_PORT  = 4'h4,
        TX_MST_ALERT = 4'h5,
        TX_ASYNC_ALR = 4'h6,
        TX_ASYNC_RPL = 4'h7,
        TX_RESPONSE  = 4'h8,
        TX_WEB_RESET = 4'h9
    } mnf_tx_e;

    typedef struct packed {
        mnf_role_e                 role;
        mnf_phase_e                phase;
        logic [`MNF_NODES-1:0]     log_q;
        logic [`MNF_NODES-1:0]     await_q;
        logic [`MNF_ALERT_W-1:0]   alerts;
        logic [`MNF_TICK_W-1:0]    pre;
        logic [`MNF_TICK_W-1:0]    ticks;
        logic [`MNF_PRIO_W-1:0]    prio;
        logic [`MNF_UID_W-1:0]     uid;
        logic                      en;
        logic                      lowering;
        logic                      wait_arpl;
        logic                      attach_hold;
        logic [`MNF_NODE_W-1:0]    attach_node;
        logic [31:0]               rdata;
        mnf_tx_e                   tx_kind;
        logic                      tx_valid;
        logic [`MNF_NODE_W-1:0]    tx_node;
        logic                      tx_cm;
        logic                      tx_ma;
        logic                      tx_bcast;
        logic                      cfg_start;
        logic                      cfg_abort;
        logic                      walk_start;
        logic                      notify_attach;
        logic                      tbl_wr;
        logic [`MNF_PRIO_W-1:0]    tbl_prio;
        logic [`MNF_NODE_W-1:0]    tbl_node;
    } mnf_state_s;

endpackage

// [bench/mnf_negotiator_assertions.sv]
// Purpose: Port-level checks of the negotiator
// Assumes: One clock, srst synchronous active high
// Notes:   Bound to every negotiator instance
`timescale 1ns/10ps
`include "mnf_cfg.svh"

module mnf_negotiator_assertions
    import mnf_pkg::*;
(
    // Clock and reset
    input wire logic                   clk,
    input wire logic                   srst,
    // Message inputs
    input wire logic                   rx_query,
    input wire logic [`MNF_NODE_W-1:0] rx_node,
    input wire logic [`MNF_PRIO_W-1:0] rx_prio,
    input wire logic                   attach_nocfg,
    input wire logic                   mst_alert_in,
    // Design outputs
    input wire logic                   tx_valid,
    input wire mnf_tx_e                tx_kind,
    input wire logic                   tx_cm,
    input wire logic                   alert_accept,
    input wire logic                   cfg_start,
    input wire logic                   cfg_abort,
    input wire logic                   notify_attach,
    input wire logic                   tbl_wr,
    input wire logic [`MNF_NODE_W-1:0] tbl_node,
    input wire logic [`MNF_PRIO_W-1:0] tbl_prio,
    input wire mnf_role_e              role
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // ------------
    // Properties
    // ------------
    property p_resign_cm; $rose(role == ROLE_RESIGN) && $past(rx_query) |-> tx_valid && tx_kind == TX_REPLY && tx_cm;
    endproperty
    a_resign_cm: assert property (p_resign_cm)
        else $error("resign no CM");
    property p_pend_cm; $rose(role == ROLE_PENDING) |-> tx_valid && tx_kind == TX_REPLY && tx_cm; endproperty
    a_pend_cm: assert property (p_pend_cm)
        else $error("pending no CM");
    property p_no_alert; role == ROLE_RESIGN |-> !alert_accept; endproperty
    a_no_alert: assert property (p_no_alert)
        else $error("alert taken in resign");
    property p_done_cm; role == ROLE_DONE && rx_query |=> tx_valid && tx_kind == TX_REPLY && !tx_cm; endproperty
    a_done_cm: assert property (p_done_cm)
        else $error("CM after resign");
    property p_assume; $rose(role == ROLE_ASSUME) |-> ##[0:2] cfg_start; endproperty
    a_assume: assert property (p_assume)
        else $error("no port config");
    property p_attach;
        attach_nocfg && role == ROLE_MASTER |=> tx_valid && tx_kind == TX_WEB_RESET ##1 notify_attach;
    endproperty
    a_attach: assert property (p_attach)
        else $error("attach order");
    property p_abort; $rose(role == ROLE_RESIGN) && $past(role) == ROLE_ASSUME |-> ##[0:1] cfg_abort; endproperty
    a_abort: assert property (p_abort)
        else $error("config kept");
    property p_table; mst_alert_in |=> tbl_wr && tbl_prio == $past(rx_prio) && tbl_node == $past(rx_node); endproperty
    a_table: assert property (p_table)
        else $error("priority not stored");

    c_done: cover property ($rose(role == ROLE_DONE));
    c_assume: cover property ($rose(role == ROLE_ASSUME));
    c_total: cover property (tx_valid && tx_kind == TX_TOTAL_RST);
endmodule

bind mnf_negotiator mnf_negotiator_assertions u_chk (.clk(clk), .srst(srst), .rx_query(rx_query),
    .rx_node(rx_node), .rx_prio(rx_prio), .attach_nocfg(attach_nocfg), .mst_alert_in(mst_alert_in),
    .tx_valid(tx_valid), .tx_kind(tx_kind), .tx_cm(tx_cm), .alert_accept(alert_accept), .cfg_start(cfg_start),
    .cfg_abort(cfg_abort), .notify_attach(notify_attach), .tbl_wr(tbl_wr), .tbl_node(tbl_node),
    .tbl_prio(tbl_prio), .role(role));

// [bench/mnf_peer_model.sv]
// Purpose: Other configuring node facing the negotiator
// Assumes: Messages are one-cycle pulses on clk
// Notes:   Priority and UID are inverted once released
`timescale 1ns/10ps
`include "mnf_cfg.svh"

module mnf_peer_model
    import mnf_pkg::*;
(
    // Clock and bench control
    input wire logic                   clk,
    input wire logic                   reply_cm,
    input wire logic                   mute,
    // Messages from the negotiator
    input wire logic                   tx_valid,
    input wire mnf_tx_e                tx_kind,
    input wire logic [`MNF_NODE_W-1:0] tx_node,
    // Messages to the negotiator
    output logic                       rx_query,
    output logic                       rx_query_ma,
    output logic                       rx_query_master,
    output logic                       rx_reply,
    output logic                       rx_reply_cm,
    output logic                       mst_alert_in,
    output logic [`MNF_NODE_W-1:0]     rx_node,
    output logic [`MNF_PRIO_W-1:0]     rx_prio,
    output logic [`MNF_UID_W-1:0]      rx_uid
);
    initial begin
        {rx_query, rx_query_ma, rx_query_master, rx_reply, rx_reply_cm, mst_alert_in} = 6'h00;
        {rx_node, rx_prio, rx_uid} = '0;
    end

    // Query or master alert; MA set marks a formal resignation
    task send(input logic k, input logic [`MNF_NODE_W-1:0] n, input logic [`MNF_PRIO_W-1:0] p,
              input logic [`MNF_UID_W-1:0] u, input logic m, input logic a);
        @(posedge clk);
        if (k) mst_alert_in <= 1'b1; else rx_query <= 1'b1;
        {rx_node, rx_prio, rx_uid, rx_query_master, rx_query_ma} <= {n, p, u, m, a};
        @(posedge clk);
        {rx_query, mst_alert_in, rx_prio, rx_uid} <= {2'b00, ~p, ~u};
    endtask

    // Answer each query unless muted, CM as told
    always @(posedge clk) begin
        rx_reply <= 1'b0;
        if (tx_valid && tx_kind == TX_QUERY && !mute) begin
            rx_reply <= 1'b1;
            rx_reply_cm <= reply_cm;
            rx_node <= tx_node;
        end else if (rx_reply) begin
            rx_reply_cm <= ~rx_reply_cm;
        end
    end
endmodule

// [bench/test_mnf_negotiator.sv]
// Purpose: Self-checking bench of the negotiator
// Assumes: Watchdog shortened to 5 ticks of 4 cycles
// Notes:   Own priority 40, unique ID 1234
`timescale 1ns/10ps
`include "mnf_cfg.svh"

module test_mnf_negotiator
    import mnf_pkg::*;
;
    logic                   clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic                   cmv = 1'b1, mute = 1'b0, nsw = 1'b0;
    logic [7:0]             reg_addr = 8'h00, bp = 8'h00;
    logic [31:0]            reg_wdata = 32'h0, reg_rdata, d;
    logic [5:0]             ev = 6'h00;
    logic                   rx_query, rx_query_ma, rx_query_master, rx_reply, rx_reply_cm, mst_alert_in;
    logic [`MNF_NODE_W-1:0] rx_node, tx_node, tbl_node;
    logic [`MNF_PRIO_W-1:0] rx_prio, tbl_prio;
    logic [`MNF_UID_W-1:0]  rx_uid;
    logic                   tx_valid, tx_cm, tx_ma, alert_accept, cfg_start, cfg_abort, walk_start;
    logic                   notify_attach, tbl_wr, bc;
    mnf_tx_e                tx_kind;
    mnf_role_e              role;
    int                     n_mismatch = 0, check_count = 0, cyc = 0, n;
    logic [7:0]             ra [4] = '{`MNF_OFS_PRIO, `MNF_OFS_UID, `MNF_OFS_CTRL, 8'h20};
    logic [31:0]            rv [4] = '{32'h0, 32'h1, 32'h0, 32'h0};
    // Query prio, uid, sender is Master, expected CM, expected role
    logic [31:0]            rows [6] = '{{8'h40, 16'h1235, 2'b01, ROLE_RESIGN}, {8'h41, 16'h0001, 2'b01, ROLE_RESIGN},
        {8'h3f, 16'hffff, 2'b00, ROLE_MASTER}, {8'h40, 16'h1233, 2'b00, ROLE_MASTER},
        {8'h40, 16'h1234, 2'b00, ROLE_MASTER}, {8'h10, 16'h0000, 2'b11, ROLE_PENDING}};

    always #50 clk = ~clk;

    mnf_negotiator #(.TICK_CYCLES(4), .TMO_TICKS(5)) DUT (.clk(clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_query(rx_query),
        .rx_query_ma(rx_query_ma), .rx_query_master(rx_query_master), .rx_reply(rx_reply),
        .rx_reply_cm(rx_reply_cm), .rx_node(rx_node), .rx_prio(rx_prio), .rx_uid(rx_uid), .alert_in(ev[5]),
        .alert_done(ev[4]), .port_op_alert(ev[3]), .port_op_new_subweb(nsw), .async_reply_in(ev[0]),
        .mst_alert_in(mst_alert_in), .attach_nocfg(ev[2]), .cfg_done(ev[1]), .best_prio(bp),
        .best_uid(16'h0000), .tx_valid(tx_valid), .tx_kind(tx_kind), .tx_node(tx_node), .tx_bcast(bc),
        .tx_cm(tx_cm), .tx_ma(tx_ma), .alert_accept(alert_accept), .cfg_start(cfg_start), .cfg_abort(cfg_abort),
        .walk_start(walk_start), .notify_attach(notify_attach), .tbl_wr(tbl_wr), .tbl_node(tbl_node),
        .tbl_prio(tbl_prio), .role(role));

    mnf_peer_model peer (.clk(clk), .reply_cm(cmv), .mute(mute), .tx_valid(tx_valid), .tx_kind(tx_kind),
        .tx_node(tx_node), .rx_query(rx_query), .rx_query_ma(rx_query_ma), .rx_query_master(rx_query_master),
        .rx_reply(rx_reply), .rx_reply_cm(rx_reply_cm), .mst_alert_in(mst_alert_in), .rx_node(rx_node),
        .rx_prio(rx_prio), .rx_uid(rx_uid));

    // ------------
    // Tasks
    // ------------
    task give_verdict;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task rst; srst <= 1'b1; repeat (3) @(posedge clk); srst <= 1'b0; endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk); {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
        @(posedge clk); reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk); {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk); reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task pulse(input logic [5:0] m); @(posedge clk); ev <= m; @(posedge clk); ev <= 6'h00; #1; endtask
    task setup; rst; wr(`MNF_OFS_PRIO, 32'h40); wr(`MNF_OFS_UID, 32'h1234); wr(`MNF_OFS_CTRL, 32'h3); @(posedge clk);
    endtask
    task ask(input logic [2:0] nd, input logic [7:0] p, input logic [15:0] u, input logic m, input logic a,
             input logic cm, input mnf_role_e r);
        peer.send(1'b0, nd, p, u, m, a);
        #1 chk("reply", {tx_valid, tx_kind, tx_cm}, {1'b1, TX_REPLY, cm});
        chk("role", role, r);
    endtask
    task wait_tx; n = 0; do begin @(posedge clk); #1; n++; end while (tx_valid !== 1'b1 && n < 60); endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin n_mismatch++; give_verdict; end
    end

    // ------------
    // Sequence
    // ------------
    initial begin
        rst;
        #1 chk("reset", {role, alert_accept, tx_valid}, {ROLE_NODE, 2'b00});
        foreach (ra[i]) begin rd(ra[i]); chk("reg", d, rv[i]); end
        @(posedge clk); #1 chk("rdata", reg_rdata, 32'h0);
        peer.send(1'b0, 3'h1, 8'hff, 16'hffff, 1'b0, 1'b0);
        #1 chk("refused", tx_valid, 1'b0);
        foreach (rows[i]) begin
            setup;
            ask(3'h2, rows[i][31:24], rows[i][23:8], rows[i][7], 1'b0, rows[i][6], mnf_role_e'(rows[i][5:0]));
        end
        setup; pulse(6'h20); pulse(6'h20);
        ask(3'h3, 8'h50, 16'h0, 1'b0, 1'b0, 1'b1, ROLE_RESIGN);
        chk("accept", alert_accept, 1'b0);
        pulse(6'h20); rd(`MNF_OFS_STATUS); chk("alerts", d[23:16], 32'h2);
        pulse(6'h10); repeat (3) @(posedge clk); #1 chk("held", role, ROLE_RESIGN);
        pulse(6'h10); wait_tx; chk("formal", {tx_kind, tx_ma, tx_node}, {TX_QUERY, 1'b1, 3'h3});
        repeat (3) @(posedge clk); #1 chk("done", role, ROLE_DONE);
        ask(3'h6, 8'h60, 16'h0, 1'b0, 1'b0, 1'b0, ROLE_DONE);
        setup; ask(3'h5, 8'h10, 16'h0, 1'b1, 1'b0, 1'b1, ROLE_PENDING);
        for (int k = 0; k < 3; k++) begin
            wait_tx;
            if (k == 1) mute = 1'b1;
            chk("wdog", n > 14 && n < 26, 1'b1);
            chk("wdog tx", {tx_kind, tx_node}, {(k < 2) ? TX_QUERY : TX_TOTAL_RST, 3'h5});
        end
        repeat (3) @(posedge clk); #1 chk("reconf", role, ROLE_ASSUME);
        mute = 1'b0;
        setup; ask(3'h5, 8'h10, 16'h0, 1'b1, 1'b0, 1'b1, ROLE_PENDING);
        ask(3'h5, 8'h10, 16'h0, 1'b1, 1'b1, 1'b0, ROLE_PENDING);
        @(posedge clk); #1 chk("assume", {role, cfg_start}, {ROLE_ASSUME, 1'b1});
        pulse(6'h08); chk("old alert", {tx_valid, walk_start}, 2'b10);
        nsw = 1'b1; pulse(6'h08); chk("walk", walk_start, 1'b1);
        nsw = 1'b0;
        ask(3'h4, 8'h50, 16'h0, 1'b0, 1'b0, 1'b1, ROLE_RESIGN);
        setup; pulse(6'h04); chk("web reset", {tx_valid, tx_kind}, {1'b1, TX_WEB_RESET});
        @(posedge clk); #1 chk("notify", notify_attach, 1'b1);
        peer.send(1'b1, 3'h2, 8'h22, 16'h0, 1'b0, 1'b0);
        #1 chk("table", {tbl_wr, tbl_node, tbl_prio}, {1'b1, 3'h2, 8'h22});
        rst; wr(`MNF_OFS_CTRL, 32'h1);
        wr(`MNF_OFS_PRIO, 32'h50); #1 chk("raise", tx_kind, TX_ASYNC_ALR);
        pulse(6'h01); chk("raised", {tx_kind, bc, role}, {TX_CFG_PORT, 1'b1, ROLE_MASTER}); bp <= 8'h20;
        wr(`MNF_OFS_PRIO, 32'h10); #1 chk("lower", {tx_kind, bc, alert_accept}, {TX_MST_ALERT, 2'b10});
        @(posedge clk); #1 chk("lowered", role, ROLE_DONE); bp <= 8'h00;
        wr(`MNF_OFS_CTRL, 32'h5); #1 chk("elect", {tx_kind, bc, role}, {TX_CFG_PORT, 1'b1, ROLE_MASTER});
        give_verdict;
    end
endmodule
